// File: hw/sg_dma_pkg.sv
// Constants, field layout and command codes of the scatter-gather DMA engine
// Functional notes
// - Page-list addressing only while command bit 4 is set.
// - Writing the list start pointer also loads the list working pointer.
// - Start fetches an entry, joins it with offset, then advances the pointer.
// - At each 4K rollover fetch the next entry and advance the pointer.
// - Transfer runs until the byte counter is zero; address then stops.
// - In element mode an interrupt follows full transfer of the element count.
// - Done and PCI address error interrupt only when bit 6 is set.
// - In list mode each finished page interrupts when bit 5 is set.
// - First assertion of the power-down request raises an interrupt.
// - A SCSI core interrupt sets status bit 4 and asserts the shared line.
// - DMA interrupt flags clear when the status register is read.
// - SCSI interrupt stays pending until its three status registers are read.
// - SCSI core signals readiness once its FIFO holds one word.
// - SCSI core requests interrupts for its own bus and command events.
// - Command field encodes idle, flush, abort, start; idle raises nothing.
// - Direction bit 7 set moves SCSI data into memory, else memory to SCSI.
package sg_dma_pkg;
   localparam logic [7:0] OFS_CMD       = 8'h40;
   localparam logic [7:0] OFS_STC       = 8'h44;
   localparam logic [7:0] OFS_SPA       = 8'h48;
   localparam logic [7:0] OFS_WBC       = 8'h4C;
   localparam logic [7:0] OFS_WAC       = 8'h50;
   localparam logic [7:0] OFS_STATUS    = 8'h54;
   localparam logic [7:0] OFS_LIST_START_POINTER     = 8'h58;
   localparam logic [7:0] OFS_LIST_WORKING_POINTER      = 8'h5C;
   localparam logic [7:0] OFS_SCSI_STAT = 8'h10;
   localparam logic [7:0] OFS_SCSI_ISR  = 8'h14;
   localparam logic [7:0] OFS_SCSI_IST  = 8'h18;

   localparam int CMD_DIR_BIT  = 7;
   localparam int CMD_TIE_BIT  = 6;
   localparam int CMD_PIE_BIT  = 5;
   localparam int CMD_LIST_BIT = 4;
   localparam int CMD_W        = 8;
   localparam int CNT_W        = 24;
   localparam int DATA_W       = 16;
   localparam int PAGE_LSB     = 12;

   localparam int ST_ERR   = 0;
   localparam int ST_PAGE  = 1;
   localparam int ST_ABORT = 2;
   localparam int ST_DONE  = 3;
   localparam int ST_SCSI  = 4;
   localparam int ST_FLUSH = 5;
   localparam int ST_POWER_DOWN_REQUEST  = 6;
   localparam int ST_W     = 7;

   localparam logic [CMD_W-1:0] CMD_RST  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST  = 24'h000000;
   localparam logic [31:0]      WORD_RST = 32'h00000000;
   localparam logic [31:0]      LIST_STEP = 32'h00000004;
   localparam logic [ST_W-1:0]  DMA_FLAG_MASK = 7'h6F;

   typedef enum logic [1:0] {
      CC_IDLE  = 2'h0,
      CC_FLUSH = 2'h1,
      CC_ABORT = 2'h2,
      CC_START = 2'h3
   } cmd_code_t;
endpackage : sg_dma_pkg

// File: hw/sg_stream_if.sv
// Valid/ready word stream between the engine and its buffer
`timescale 1ns/100ps
interface sg_stream_if #(parameter int W = 16);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sg_stream_if

// File: hw/sg_buf2.sv
// Two-entry elastic buffer in the data path
`timescale 1ns/100ps
module sg_buf2 (
   input wire logic core_clk,
   input wire logic rst_n,
   sg_stream_if.snk wr,
   sg_stream_if.src rd
);
   logic [1:0]            cnt_q;
   logic [$bits(wr.data)-1:0] d0_q;
   logic [$bits(wr.data)-1:0] d1_q;
   wire push = wr.valid & wr.ready;
   wire pop  = rd.valid & rd.ready;

   assign wr.ready = (cnt_q != 2'h2);
   assign rd.valid = (cnt_q != 2'h0);
   assign rd.data  = d0_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_q <= 2'h0;
         d0_q  <= '0;
         d1_q  <= '0;
      end else begin
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
         if (pop) begin
            d0_q <= (cnt_q == 2'h2) ? d1_q : wr.data;
         end else if (push && cnt_q == 2'h0) begin
            d0_q <= wr.data;
         end
         if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == 2'h2)) begin
            d1_q <= wr.data;
         end
      end
   end
endmodule : sg_buf2

// File: hw/sg_flags.sv
// Sticky event flags; a set in the clearing cycle survives
`timescale 1ns/100ps
module sg_flags #(parameter int W = 7) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= (q & ~clr) | set;
      end
   end
endmodule : sg_flags

// File: hw/sg_dma_engine.sv
// Scatter-gather DMA engine between host memory and the SCSI FIFO
`timescale 1ns/100ps
module sg_dma_engine import sg_dma_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   output logic      [31:0]       reg_rdata,
   output logic                   mem_req,
   output logic                   mem_we,
   output logic      [31:0]       mem_addr,
   output logic      [3:0]        mem_be,
   output logic      [31:0]       mem_wdata,
   input  wire logic              mem_ack,
   input  wire logic              mem_err,
   input  wire logic [31:0]       mem_rdata,
   input  wire logic              scsi_in_valid,
   output logic                   scsi_in_ready,
   input  wire logic [DATA_W-1:0] scsi_in_data,
   output logic                   scsi_out_valid,
   input  wire logic              scsi_out_ready,
   output logic      [DATA_W-1:0] scsi_out_data,
   input  wire logic              scsi_irq_req,
   input  wire logic              power_down_request,
   output logic                   pci_inta_n
);
   typedef enum logic [2:0] {
      S_IDLE, S_LIST, S_MOVE, S_MEM, S_FLUSH, S_DONE
   } state_t;

   state_t           state_q;
   state_t           state_d;
   logic [CMD_W-1:0] cmd_q;
   logic [CNT_W-1:0] stc_q;
   logic [CNT_W-1:0] wbc_q;
   logic [31:0]      spa_q;
   logic [31:0]      wac_q;
   logic [31:0]      list_start_pointer_q;
   logic [31:0]      list_working_pointer_q;
   logic [31:0]      rdata_q;
   logic             req_q;
   logic             we_q;
   logic [31:0]      addr_q;
   logic [3:0]       be_q;
   logic [31:0]      wdata_q;
   logic             flushing_q;
   logic             power_down_request_prev_q;
   logic             irq_q;
   logic [2:0]       seen_q;
   logic [ST_W-1:0]  flag_q;
   logic [ST_W-1:0]  flag_set;
   logic [ST_W-1:0]  flag_clr;

   sg_stream_if #(.W(DATA_W)) buf_wr ();
   sg_stream_if #(.W(DATA_W)) buf_rd ();

   sg_buf2 u_buf (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr       (buf_wr),
      .rd       (buf_rd)
   );

   sg_flags #(.W(ST_W)) u_flags (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .set      (flag_set),
      .clr      (flag_clr),
      .q        (flag_q)
   );

   // Register decode
   wire hit_cmd   = (reg_addr == OFS_CMD);
   wire wr_cmd    = reg_wr & hit_cmd;
   wire wr_stc    = reg_wr & (reg_addr == OFS_STC);
   wire wr_spa    = reg_wr & (reg_addr == OFS_SPA);
   wire wr_list_start_pointer  = reg_wr & (reg_addr == OFS_LIST_START_POINTER);
   wire rd_status = reg_rd & (reg_addr == OFS_STATUS);
   wire [2:0] rd_scsi = {reg_rd & (reg_addr == OFS_SCSI_IST),
                         reg_rd & (reg_addr == OFS_SCSI_ISR),
                         reg_rd & (reg_addr == OFS_SCSI_STAT)};

   wire [1:0] new_code = reg_wdata[1:0];
   wire idle_st   = (state_q == S_IDLE) | (state_q == S_DONE);
   wire start_req = wr_cmd & (new_code == CC_START) & idle_st;
   wire abort_req = wr_cmd & (new_code == CC_ABORT) & (state_q != S_IDLE);
   wire idle_req  = wr_cmd & (new_code == CC_IDLE);
   wire flush_req = wr_cmd & (new_code == CC_FLUSH) & idle_st & reg_wdata[CMD_DIR_BIT];

   wire dir_to_mem = cmd_q[CMD_DIR_BIT];
   wire list_en    = cmd_q[CMD_LIST_BIT];

   // Halfword moves on even addresses with more than one byte left; single bytes otherwise
   wire [1:0]  step     = (!wac_q[0] && wbc_q != 24'h000001) ? 2'h2 : 2'h1;
   wire [31:0] wac_inc  = wac_q + {30'h0, step};
   wire [CNT_W-1:0] wbc_dec = (wbc_q > {22'h0, step}) ? wbc_q - {22'h0, step} : CNT_RST;
   wire page_roll = list_en & (wac_inc[PAGE_LSB-1:0] == 12'h000) & (wbc_dec != CNT_RST);

   wire mem_busy  = (state_q == S_MEM) | (state_q == S_LIST);
   wire ack_ok    = mem_ack & ~mem_err;
   wire list_done = (state_q == S_LIST) & ack_ok;
   wire move_done = (state_q == S_MEM) & ack_ok;
   wire pop_wr    = move_done & we_q;
   wire push_rd   = move_done & ~we_q;
   wire launch    = ((state_d == S_MEM) | (state_d == S_LIST)) &
                    ((state_d != state_q) | mem_ack);

   wire [31:0]       rd_shift = mem_rdata >> {wac_q[1:0], 3'h0};
   wire [DATA_W-1:0] rd_lane  = rd_shift[DATA_W-1:0];
   wire [31:0]       wr_shift = {16'h0, buf_rd.data} << {wac_q[1:0], 3'h0};
   wire [3:0]        be_new   = ((step == 2'h2) ? 4'h3 : 4'h1) << wac_q[1:0];

   // Buffer steering by direction
   assign buf_wr.valid   = dir_to_mem ? scsi_in_valid : push_rd;
   assign buf_wr.data    = dir_to_mem ? scsi_in_data : rd_lane;
   assign scsi_in_ready  = dir_to_mem & buf_wr.ready;
   assign buf_rd.ready   = dir_to_mem ? pop_wr : scsi_out_ready;
   assign scsi_out_valid = ~dir_to_mem & buf_rd.valid;
   assign scsi_out_data  = buf_rd.data;

   // SCSI flag clears only once all three core registers were read
   wire scsi_all = ((seen_q | rd_scsi) == 3'h7);

   assign flag_set[ST_ERR]   = mem_busy & mem_ack & mem_err;
   assign flag_set[ST_PAGE]  = move_done & page_roll;
   assign flag_set[ST_ABORT] = abort_req;
   assign flag_set[ST_DONE]  = (state_q == S_MOVE) & (wbc_q == CNT_RST);
   assign flag_set[ST_SCSI]  = scsi_irq_req;
   assign flag_set[ST_FLUSH] = (state_q == S_FLUSH) & ~buf_rd.valid;
   assign flag_set[ST_POWER_DOWN_REQUEST]  = power_down_request & ~power_down_request_prev_q;
   assign flag_clr = rd_status ? DMA_FLAG_MASK : {{(ST_W-ST_SCSI-1){1'b0}},
                     scsi_all & flag_q[ST_SCSI], {ST_SCSI{1'b0}}};

   wire irq_d = (cmd_q[CMD_TIE_BIT] & (flag_q[ST_ERR] | flag_q[ST_DONE])) |
                (cmd_q[CMD_PIE_BIT] & flag_q[ST_PAGE]) |
                flag_q[ST_POWER_DOWN_REQUEST] | flag_q[ST_SCSI];

   wire [31:0] rd_mux =
      hit_cmd                    ? {24'h0, cmd_q} :
      (reg_addr == OFS_STC)      ? {8'h0, stc_q} :
      (reg_addr == OFS_SPA)      ? spa_q :
      (reg_addr == OFS_WBC)      ? {8'h0, wbc_q} :
      (reg_addr == OFS_WAC)      ? wac_q :
      (reg_addr == OFS_STATUS)   ? {25'h0, flag_q} :
      (reg_addr == OFS_LIST_START_POINTER)    ? list_start_pointer_q :
      (reg_addr == OFS_LIST_WORKING_POINTER)     ? list_working_pointer_q : WORD_RST;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_IDLE, S_DONE: begin
            if (start_req) begin
               state_d = reg_wdata[CMD_LIST_BIT] ? S_LIST : S_MOVE;
            end else if (flush_req) begin
               state_d = S_FLUSH;
            end
         end
         S_LIST: begin
            if (mem_ack) begin
               state_d = mem_err ? S_DONE : S_MOVE;
            end
         end
         S_MOVE: begin
            if (wbc_q == CNT_RST) begin
               state_d = S_DONE;
            end else if (dir_to_mem ? buf_rd.valid : buf_wr.ready) begin
               state_d = S_MEM;
            end
         end
         S_MEM: begin
            if (mem_ack) begin
               if (mem_err) begin
                  state_d = S_DONE;
               end else if (flushing_q) begin
                  state_d = S_FLUSH;
               end else if (page_roll) begin
                  state_d = S_LIST;
               end else begin
                  state_d = S_MOVE;
               end
            end
         end
         S_FLUSH: begin
            state_d = buf_rd.valid ? S_MEM : S_DONE;
         end
      endcase
      if (abort_req || idle_req) begin
         state_d = S_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q     <= S_IDLE;
         cmd_q       <= CMD_RST;
         stc_q       <= CNT_RST;
         spa_q       <= WORD_RST;
         list_start_pointer_q     <= WORD_RST;
         rdata_q     <= WORD_RST;
         power_down_request_prev_q <= 1'b0;
         irq_q       <= 1'b0;
         flushing_q  <= 1'b0;
         seen_q      <= 3'h0;
      end else begin
         state_q     <= state_d;
         power_down_request_prev_q <= power_down_request;
         irq_q       <= irq_d;
         if (reg_rd) rdata_q <= rd_mux;
         if (wr_cmd) cmd_q <= reg_wdata[CMD_W-1:0];
         if (wr_stc) stc_q <= reg_wdata[CNT_W-1:0];
         if (wr_spa) spa_q <= reg_wdata;
         if (wr_list_start_pointer) list_start_pointer_q <= reg_wdata;
         if (flush_req) flushing_q <= 1'b1;
         else if (state_d == S_IDLE || state_d == S_DONE) flushing_q <= 1'b0;
         seen_q <= (flag_set[ST_SCSI] || flag_clr[ST_SCSI]) ? 3'h0 : seen_q | rd_scsi;
      end
   end

   // Working counters and list pointer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wac_q  <= WORD_RST;
         wbc_q  <= CNT_RST;
         list_working_pointer_q <= WORD_RST;
      end else begin
         if (start_req) begin
            wac_q <= spa_q;
            wbc_q <= stc_q;
         end else if (list_done) begin
            wac_q <= {mem_rdata[31:PAGE_LSB], wac_q[PAGE_LSB-1:0]};
         end else if (move_done) begin
            wac_q <= wac_inc;
            wbc_q <= wbc_dec;
         end
         if (wr_list_start_pointer) begin
            list_working_pointer_q <= reg_wdata;
         end else if (list_done) begin
            list_working_pointer_q <= list_working_pointer_q + LIST_STEP;
         end
      end
   end

   // Memory request registers; request held until acknowledged or dropped by an abort or idle command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         req_q   <= 1'b0;
         we_q    <= 1'b0;
         addr_q  <= WORD_RST;
         be_q    <= 4'h0;
         wdata_q <= WORD_RST;
      end else begin
         req_q <= (state_d == S_MEM) | (state_d == S_LIST);
         if (launch) begin
            we_q    <= (state_d == S_MEM) & dir_to_mem;
            addr_q  <= (state_d == S_LIST) ? list_working_pointer_q : wac_q;
            be_q    <= (state_d == S_LIST) ? 4'hF : be_new;
            wdata_q <= wr_shift;
         end
      end
   end

   assign reg_rdata  = rdata_q;
   assign mem_req    = req_q;
   assign mem_we     = we_q;
   assign mem_addr   = addr_q;
   assign mem_be     = be_q;
   assign mem_wdata  = wdata_q;
   assign pci_inta_n = ~irq_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_list_copy: assert property (wr_list_start_pointer |=> list_working_pointer_q == $past(reg_wdata))
      else $error("list working pointer not loaded with start pointer");

   chk_list_gate: assert property (state_q == S_LIST |-> cmd_q[CMD_LIST_BIT])
      else $error("list fetch without list enable");

   chk_entry_join: assert property (list_done && !wr_list_start_pointer |=>
      list_working_pointer_q == $past(list_working_pointer_q) + LIST_STEP &&
      wac_q[31:PAGE_LSB] == $past(mem_rdata[31:PAGE_LSB]) && $stable(wac_q[11:0]))
      else $error("list entry not joined or pointer not advanced");

   chk_page_fetch: assert property (move_done && page_roll && !abort_req && !idle_req
      |=> state_q == S_LIST && mem_req && mem_addr == list_working_pointer_q)
      else $error("no entry fetch at page rollover");

   chk_stop_zero: assert property (state_q == S_MOVE && wbc_q == CNT_RST && !wr_cmd
      |=> state_q == S_DONE ##1 $stable(wac_q))
      else $error("working address moved after count reached zero");

   chk_count_pair: assert property (move_done && !start_req |=>
      (wac_q - $past(wac_q)) == {30'h0, $past(step)} &&
      ($past(wbc_q) - wbc_q) <= {22'h0, $past(step)})
      else $error("address and count moved by different amounts");

   chk_done_irq: assert property (flag_set[ST_DONE] && cmd_q[CMD_TIE_BIT] && !rd_status
      && !wr_cmd |-> ##2 !pci_inta_n)
      else $error("done without interrupt");

   chk_status_clear: assert property (rd_status && !flag_set[ST_DONE] |=> !flag_q[ST_DONE])
      else $error("done flag survived status read");

   chk_scsi_hold: assert property (flag_q[ST_SCSI] && !scsi_all |=> flag_q[ST_SCSI])
      else $error("SCSI flag cleared early");

   chk_power_down_request_irq: assert property ($rose(power_down_request) |=> flag_q[ST_POWER_DOWN_REQUEST]
      ##1 !pci_inta_n)
      else $error("power-down request raised no interrupt");

   chk_idle_quiet: assert property (idle_req |=> state_q == S_IDLE && !mem_req)
      else $error("idle command did not stop engine");
endmodule : sg_dma_engine

// File: tb/host_mem_model.sv
// Host memory model answering the engine's word requests
`timescale 1ns/100ps
module host_mem_model (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [3:0]  mem_be,
   input  wire logic [31:0] mem_wdata,
   input  wire logic        slow,
   input  wire logic        err_en,
   output logic             mem_ack = 1'b0,
   output logic             mem_err = 1'b0,
   output logic      [31:0] mem_rdata = 32'h0
);
   logic [31:0] mem [0:255];
   logic [31:0] held_q = 32'h0;
   int          wait_q = 0;
   int          seed_q = 43;
   wire  [7:0]  idx = mem_addr[9:2];

   // Released read lines show the inverse, never a stale match
   always @(posedge core_clk) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~held_q;
      if (!rst_n) begin
         wait_q <= 0;
      end else if (mem_req && !mem_ack) begin
         if (wait_q > 0) begin
            wait_q <= wait_q - 1;
         end else begin
            mem_ack <= 1'b1;
            mem_err <= err_en;
            wait_q <= slow ? ($random(seed_q) & 3) : 0;
            if (mem_we) begin
               for (int b = 0; b < 4; b++) begin
                  if (mem_be[b]) mem[idx][8*b+:8] <= mem_wdata[8*b+:8];
               end
            end else begin
               mem_rdata <= mem[idx];
               held_q <= mem[idx];
            end
         end
      end
   end
endmodule : host_mem_model

// File: tb/tb.sv
// Self-checking bench for the scatter-gather DMA engine
`timescale 1ns/100ps
module tb import sg_dma_pkg::*;;
   logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
   logic        mem_req, mem_we, mem_ack, mem_err, pci_inta_n;
   logic        scsi_in_valid = 0, scsi_in_ready, scsi_out_valid, scsi_out_ready = 0;
   logic        scsi_irq_req = 0, power_down_request = 0, slow = 0, err_en = 0;
   logic        out_stall = 0, took_in = 0;
   logic [7:0]  reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd, rv;
   logic [31:0] pre [0:3];
   logic [3:0]  mem_be;
   logic [15:0] scsi_in_data = 0, scsi_out_data;
   int          seed = 43, fail_count = 0, cmp_count = 0;
   int          out_idx = 0, in_idx = 0, in_n = 0, i, k;

   always #5 core_clk = ~core_clk;

   sg_dma_engine dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
      .scsi_in_valid(scsi_in_valid), .scsi_in_ready(scsi_in_ready),
      .scsi_in_data(scsi_in_data), .scsi_out_valid(scsi_out_valid),
      .scsi_out_ready(scsi_out_ready), .scsi_out_data(scsi_out_data),
      .scsi_irq_req(scsi_irq_req), .power_down_request(power_down_request),
      .pci_inta_n(pci_inta_n));

   host_mem_model pm_u (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
      .slow(slow), .err_en(err_en), .mem_ack(mem_ack), .mem_err(mem_err),
      .mem_rdata(mem_rdata));

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   function automatic logic [15:0] exp_hw(input int n);
      return n[0] ? pre[n/2][31:16] : pre[n/2][15:0];
   endfunction : exp_hw

   // SCSI side: source holds each word until taken, sink stalls at random
   always @(posedge core_clk) begin
      took_in <= scsi_in_valid && scsi_in_ready;
      if (scsi_out_valid && scsi_out_ready) begin
         check("out word", {16'h0, scsi_out_data}, {16'h0, exp_hw(out_idx)});
         out_idx++;
      end
   end

   always @(negedge core_clk) begin
      if (took_in) in_idx = in_idx + 1;
      scsi_in_valid <= in_idx < in_n;
      scsi_in_data <= 16'hA500 + in_idx[15:0];
      scsi_out_ready <= !out_stall && (($random(seed) & 3) != 0);
   end

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge core_clk);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 0;
   endtask : wr

   task rdr(input logic [7:0] a, output logic [31:0] d);
      @(negedge core_clk);
      reg_rd = 1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 0;
      d = reg_rdata;
   endtask : rdr

   task wait_irq;
      i = 0;
      while (pci_inta_n !== 1'b0 && i < 60) begin
         @(negedge core_clk);
         i++;
      end
      check("irq line", {31'h0, pci_inta_n}, 32'h0);
   endtask : wait_irq

   task wait_zero;
      i = 0;
      do begin
         rdr(8'h4C, rv);
         i++;
      end while (rv !== 32'h0 && i < 300);
      // A count that never drains is a failure, not a silent fall-through
      check("count drained", rv, 32'h0);
      repeat (6) @(negedge core_clk);
   endtask : wait_zero

   task run(input logic [31:0] a, input logic [31:0] n, input logic [31:0] c);
      wr(8'h44, n);
      wr(8'h48, a);
      wr(8'h40, c);
   endtask : run

   task load_pre(input logic [7:0] base);
      for (k = 0; k < 4; k++) begin
         pre[k] = $random(seed);
         pm_u.mem[base+k[7:0]] = pre[k];
      end
      out_idx = 0;
   endtask : load_pre

   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize

   initial begin
      #300000;
      fail_count++;
      summarize();
   end

   initial begin
      repeat (12) @(negedge core_clk);
      rst_n = 1;
      check("irq idle", {31'h0, pci_inta_n}, 32'h1);
      rdr(8'h40, rd);
      check("command reset", rd, 32'h0);
      rdr(8'h60, rd);
      check("unmapped read", rd, 32'h0);
      rd = $random(seed) & 32'hFFFFFFFC;
      wr(8'h58, rd);
      rdr(8'h5C, rv);
      check("list pointer copy", rv, rd);
      // Element transfers, done interrupt masked then enabled
      for (int e = 0; e < 2; e++) begin
         load_pre(8'h40);
         run(32'h100, 32'(8 - 2 * e), e ? 32'h43 : 32'h03);
         wait_zero();
         check("irq gate", {31'h0, pci_inta_n}, 32'(1 - e));
         rdr(8'h54, rd);
         check("done flag", rd, 32'h08);
         rdr(8'h54, rd);
         check("flag cleared", rd, 32'h0);
         rdr(8'h50, rd);
         check("end address", rd, 32'(32'h108 - 2 * e));
         check("words out", 32'(out_idx), 32'(4 - e));
         wr(8'h40, 32'h0);
         rdr(8'h54, rd);
         check("idle quiet", rd, 32'h0);
      end
      // Page list crossing one 4K boundary, slow memory
      slow = 1;
      load_pre(8'hFE);
      pm_u.mem[8'h00] = pre[2];
      pm_u.mem[8'h01] = pre[3];
      pm_u.mem[8'hC0] = 32'h00005ABC;
      pm_u.mem[8'hC1] = 32'h00006123;
      wr(8'h58, 32'h300);
      run(32'hFF8, 32'h10, 32'h33);
      wait_irq();
      wait_zero();
      rdr(8'h54, rd);
      check("page and done", rd, 32'h0A);
      rdr(8'h50, rd);
      check("list address", rd, 32'h6008);
      rdr(8'h5C, rd);
      check("list pointer", rd, 32'h308);
      check("list words", 32'(out_idx), 32'h8);
      wr(8'h40, 32'h0);
      slow = 0;
      // SCSI into memory
      in_idx = 0;
      in_n = 4;
      run(32'h200, 32'h8, 32'hC3);
      wait_zero();
      check("mem word 0", pm_u.mem[8'h80], 32'hA501A500);
      check("mem word 1", pm_u.mem[8'h81], 32'hA503A502);
      rdr(8'h54, rd);
      wr(8'h40, 32'h0);
      // Address error
      err_en = 1;
      load_pre(8'h40);
      run(32'h100, 32'h8, 32'h43);
      wait_irq();
      err_en = 0;
      rdr(8'h54, rd);
      check("error flag", rd & 32'h01, 32'h01);
      wr(8'h40, 32'h0);
      // Power-down request edge
      @(negedge core_clk);
      power_down_request = 1;
      wait_irq();
      rdr(8'h54, rd);
      check("power flag", rd, 32'h40);
      rdr(8'h54, rd);
      check("level no repeat", rd, 32'h0);
      // SCSI core event
      @(negedge core_clk);
      scsi_irq_req = 1;
      @(negedge core_clk);
      scsi_irq_req = 0;
      wait_irq();
      rdr(8'h54, rd);
      check("scsi flag", rd, 32'h10);
      rdr(8'h54, rd);
      check("scsi pending", rd, 32'h10);
      rdr(8'h10, rd);
      rdr(8'h14, rd);
      rdr(8'h18, rd);
      rdr(8'h54, rd);
      check("scsi cleared", rd, 32'h0);
      // Abort mid transfer, then flush from idle
      in_idx = 0;
      in_n = 2;
      run(32'h200, 32'h8, 32'h83);
      repeat (20) @(negedge core_clk);
      wr(8'h40, 32'h82);
      rdr(8'h54, rd);
      check("abort flag", rd, 32'h04);
      wr(8'h40, 32'h81);
      repeat (20) @(negedge core_clk);
      rdr(8'h54, rd);
      check("flush flag", rd, 32'h20);
      wr(8'h40, 32'h0);
      summarize();
   end
endmodule : tb
